/* File: common/cag_pkg.sv */
// Purpose: Shared constants and types for the add-group execution unit
// Assumes: APB register access with 32-bit data, 16-bit general registers
// Notes: Offsets, control and status bit positions, quick codes and data reset values live here
package cag_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int NUM_GPR = 8;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_QCODE = 12'h004;
  localparam logic [11:0] OFS_SRC = 12'h008;
  localparam logic [11:0] OFS_MEM = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_GPR = 12'h020;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WORD_BIT = 2;
  localparam int CTRL_RD_LSB = 4;
  localparam int CTRL_MEM_BIT = 8;
  localparam int CTRL_GO_BIT = 16;
  localparam int STAT_BAD_BIT = 4;
  localparam int STAT_BUSY_BIT = 8;

  // ----------------------------------------------------------------
  // Quick-add operation bytes and their immediates
  // ----------------------------------------------------------------
  localparam logic [7:0] QC_PLUS1 = 8'h08;
  localparam logic [7:0] QC_PLUS2 = 8'h09;
  localparam logic [7:0] QC_MINUS1 = 8'h0c;
  localparam logic [7:0] QC_MINUS2 = 8'h0d;
  localparam logic [15:0] IMM_PLUS1 = 16'h0001;
  localparam logic [15:0] IMM_PLUS2 = 16'h0002;
  localparam logic [15:0] IMM_MINUS1 = 16'hffff;
  localparam logic [15:0] IMM_MINUS2 = 16'hfffe;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] QCODE_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_GEN = 2'h0,
    OP_QUICK = 2'h1,
    OP_SEXT = 2'h2,
    OP_BAD = 2'h3
  } cag_op_t;

  typedef enum logic {
    S_IDLE = 1'b0,
    S_EXEC = 1'b1
  } cag_state_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cag_flags_t;

  localparam cag_flags_t FLAGS_RST = 4'h0;

  typedef struct packed {
    cag_state_t state;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cag_op_t op;
    logic word;
    logic [2:0] rd;
    logic dst_mem;
    logic [7:0] qcode;
    logic [15:0] src;
    logic [15:0] mem;
    cag_flags_t flags;
    logic bad;
    logic [NUM_GPR-1:0][15:0] gpr;
  } cag_st_t;

endpackage

/* File: rtl/cag_adder.sv */
// Purpose: Size-aware adder with condition flags
// Assumes: Combinational; caller decides whether flags are kept
// Notes: Byte results keep the destination upper byte
`timescale 1ns/100ps
module cag_adder (
  // Operands
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  // Mode
  input wire logic word,
  input wire logic sext,
  // Result
  output logic [15:0] sum,
  output cag_pkg::cag_flags_t flags
);

  logic [8:0] s8;
  logic [16:0] s16;
  logic [15:0] bx;

  always_comb begin
    // Byte source widened by its sign bit, always a word add
    bx = (sext && !word) ? {{8{b[7]}}, b[7:0]} : b;  // [RL10]
    s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
    s16 = {1'b0, a} + {1'b0, bx};
    if (word || sext) begin
      sum = s16[15:0];                                // [RL11]
      flags.n = s16[15];
      flags.z = (s16[15:0] == 16'h0000);
      flags.v = (a[15] == bx[15]) && (s16[15] != a[15]);
      flags.c = s16[16];
    end else begin
      sum = {a[15:8], s8[7:0]};                       // [RL12]
      flags.n = s8[7];
      flags.z = (s8[7:0] == 8'h00);
      flags.v = (a[7] == b[7]) && (s8[7] != a[7]);
      flags.c = s8[8];
    end
  end

endmodule // cag_adder

/* File: rtl/cag_exec.sv */
// Purpose: Add-group execution unit with an APB register window
// Assumes: Single 100 MHz clock pclk, asynchronous active-low presetn
// Notes: One execution cycle follows each start; flags live in STATUS
//
// Overview of operation
// RL1 - General add sums source into destination register
// RL2 - Negative flag follows result top bit
// RL3 - Zero flag set when sized result zero
// RL4 - Overflow flag marks signed overflow
// RL5 - Carry flag marks unsigned carry out
// RL6 - Quick add updates register or memory operand
// RL7 - Quick immediates limited to plus/minus one, two
// RL8 - Four quick operation byte codes recognised
// RL9 - Sign-extending add leaves flags unchanged
// RL10 - Byte source sign-extended to sixteen bits
// RL11 - Sign-extending add uses full word destination
// RL12 - Byte adds confined to low eight bits
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module cag_exec #(
  parameter int ADDR_W = cag_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Condition flags
  output cag_pkg::cag_flags_t flags
);

  // ----------------------------------------------------------------
  // State and datapath signals
  // ----------------------------------------------------------------
  cag_pkg::cag_st_t st;
  cag_pkg::cag_st_t next_st;
  logic [11:0] addr;
  logic hit;
  logic gpr_hit;
  logic [2:0] gpr_idx;
  logic [31:0] rd_data;
  logic acc_wr;
  logic setup_done;
  logic [15:0] add_a;
  logic [15:0] add_b;
  logic add_sext;
  logic [15:0] add_sum;
  cag_pkg::cag_flags_t add_flags;
  logic [15:0] q_imm;
  logic q_valid;
  logic exec;
  logic ok;
  logic bad_set;
  logic bad_clr;

  assign addr = 12'(paddr);
  assign setup_done = psel & penable & ~st.pready;
  assign acc_wr = psel & penable & st.pready & pwrite & hit;
  assign exec = (st.state == cag_pkg::S_EXEC);

  // ----------------------------------------------------------------
  // Operand routing
  // ----------------------------------------------------------------
  cag_qdec u_qdec (
    .code(st.qcode),
    .imm(q_imm),
    .valid(q_valid)
  );

  always_comb begin
    add_a = st.gpr[st.rd];
    add_b = st.src;
    add_sext = (st.op == cag_pkg::OP_SEXT);
    if (st.op == cag_pkg::OP_QUICK) begin
      add_a = st.dst_mem ? st.mem : st.gpr[st.rd];  // [RL6]
      add_b = q_imm;                                // [RL7]
    end
    unique case (st.op)
      cag_pkg::OP_GEN: ok = 1'b1;
      cag_pkg::OP_QUICK: ok = q_valid;              // [RL7]
      cag_pkg::OP_SEXT: ok = 1'b1;
      default: ok = 1'b0;
    endcase
  end

  cag_adder u_adder (
    .a(add_a),
    .b(add_b),
    .word(st.word),
    .sext(add_sext),
    .sum(add_sum),
    .flags(add_flags)
  );

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    gpr_hit = (addr[11:5] == cag_pkg::OFS_GPR[11:5]) && (addr[1:0] == 2'h0);
    gpr_idx = addr[4:2];
    hit = 1'b1;
    rd_data = cag_pkg::RDATA_RST;
    if (gpr_hit) begin
      rd_data[15:0] = st.gpr[gpr_idx];
    end else begin
      unique case (addr)
        cag_pkg::OFS_CTRL: begin
          rd_data[cag_pkg::CTRL_OP_LSB +: 2] = st.op;
          rd_data[cag_pkg::CTRL_WORD_BIT] = st.word;
          rd_data[cag_pkg::CTRL_RD_LSB +: 3] = st.rd;
          rd_data[cag_pkg::CTRL_MEM_BIT] = st.dst_mem;
        end
        cag_pkg::OFS_QCODE: rd_data[7:0] = st.qcode;
        cag_pkg::OFS_SRC: rd_data[15:0] = st.src;
        cag_pkg::OFS_MEM: rd_data[15:0] = st.mem;
        cag_pkg::OFS_STATUS: begin
          rd_data[3:0] = st.flags;
          rd_data[cag_pkg::STAT_BAD_BIT] = st.bad;
          rd_data[cag_pkg::STAT_BUSY_BIT] = exec;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    bad_set = exec && !ok;                          // [RL7]
    bad_clr = acc_wr && (addr == cag_pkg::OFS_STATUS) && pwdata[cag_pkg::STAT_BAD_BIT];
    // Answer one cycle into the access phase, so data is registered
    next_st.pready = setup_done;
    if (setup_done) begin
      next_st.prdata = rd_data;
      next_st.pslverr = ~hit;
    end
    if (acc_wr) begin
      if (gpr_hit) begin
        next_st.gpr[gpr_idx] = pwdata[15:0];
      end else begin
        unique case (addr)
          cag_pkg::OFS_CTRL: begin
            next_st.op = cag_pkg::cag_op_t'(pwdata[cag_pkg::CTRL_OP_LSB +: 2]);
            next_st.word = pwdata[cag_pkg::CTRL_WORD_BIT];
            next_st.rd = pwdata[cag_pkg::CTRL_RD_LSB +: 3];
            next_st.dst_mem = pwdata[cag_pkg::CTRL_MEM_BIT];
            if (pwdata[cag_pkg::CTRL_GO_BIT]) begin
              next_st.state = cag_pkg::S_EXEC;
            end
          end
          cag_pkg::OFS_QCODE: next_st.qcode = pwdata[7:0];
          cag_pkg::OFS_SRC: next_st.src = pwdata[15:0];
          cag_pkg::OFS_MEM: next_st.mem = pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
    if (exec) begin
      next_st.state = cag_pkg::S_IDLE;
      if (ok) begin
        unique case (st.op)
          cag_pkg::OP_GEN: begin
            next_st.gpr[st.rd] = add_sum;           // [RL1] [RL12]
            next_st.flags = add_flags;              // [RL2] [RL3] [RL4] [RL5]
          end
          cag_pkg::OP_QUICK: begin
            if (st.dst_mem) begin
              next_st.mem = add_sum;                // [RL6]
            end else begin
              next_st.gpr[st.rd] = add_sum;         // [RL6]
            end
            next_st.flags = add_flags;              // [RL2] [RL3] [RL4] [RL5]
          end
          default: begin
            next_st.gpr[st.rd] = add_sum;           // [RL9] [RL11]
          end
        endcase
      end
    end
    // A fault raised in the clearing cycle stays visible
    next_st.bad = (st.bad & ~bad_clr) | bad_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{state: cag_pkg::S_IDLE, pready: 1'b0, pslverr: 1'b0, prdata: cag_pkg::RDATA_RST,
              op: cag_pkg::OP_GEN, word: 1'b0, rd: 3'h0, dst_mem: 1'b0, qcode: cag_pkg::QCODE_RST,
              src: cag_pkg::DATA_RST, mem: cag_pkg::DATA_RST, flags: cag_pkg::FLAGS_RST, bad: 1'b0,
              gpr: '0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign flags = st.flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Independent reference values, sized per operand width
  logic [16:0] chk_w;
  logic [8:0] chk_b;
  logic chk_n;
  logic chk_z;
  logic chk_v;
  logic chk_c;
  logic upd;
  logic [15:0] chk_sx;
  logic [15:0] dst_now;
  logic [15:0] chk_qimm;

  always_comb begin
    chk_w = {1'b0, add_a} + {1'b0, add_b};
    chk_b = {1'b0, add_a[7:0]} + {1'b0, add_b[7:0]};
    chk_n = st.word ? chk_w[15] : chk_b[7];
    chk_z = st.word ? (chk_w[15:0] == 16'h0000) : (chk_b[7:0] == 8'h00);
    chk_v = st.word ? ((add_a[15] ~^ add_b[15]) & (chk_w[15] ^ add_a[15]))
                    : ((add_a[7] ~^ add_b[7]) & (chk_b[7] ^ add_a[7]));
    chk_c = st.word ? chk_w[16] : chk_b[8];
    chk_sx = st.gpr[st.rd] + (st.word ? st.src : {{8{st.src[7]}}, st.src[7:0]});
    upd = exec && ok && (st.op != cag_pkg::OP_SEXT);
    dst_now = st.gpr[st.rd];
    // Immediate rebuilt from the code bits, not taken from the decoder
    chk_qimm = st.qcode[2] ? (16'h0000 - {15'h0000, st.qcode[0]} - 16'h0001) : ({15'h0000, st.qcode[0]} + 16'h0001);
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_gen_result: assert property (exec && st.op == cag_pkg::OP_GEN && st.word // [RL1]
    |=> st.gpr[st.rd] == $past(chk_w[15:0])) else $error("general add result wrong");
  a_gen_byte: assert property (exec && st.op == cag_pkg::OP_GEN && !st.word // [RL1]
    |=> st.gpr[st.rd][7:0] == $past(chk_b[7:0])) else $error("general byte add result wrong");
  a_neg_flag: assert property (upd |=> st.flags.n == $past(chk_n)) // [RL2]
    else $error("negative flag wrong");
  a_zero_flag: assert property (upd |=> st.flags.z == $past(chk_z)) // [RL3]
    else $error("zero flag wrong");
  a_ovf_flag: assert property (upd |=> st.flags.v == $past(chk_v)) // [RL4]
    else $error("overflow flag wrong");
  a_carry_flag: assert property (upd |=> st.flags.c == $past(chk_c)) // [RL5]
    else $error("carry flag wrong");
  a_quick_mem: assert property (exec && ok && st.op == cag_pkg::OP_QUICK && st.dst_mem // [RL6]
    |=> st.mem == $past(add_sum) && $stable(st.gpr)) else $error("quick memory write wrong");
  a_quick_reg: assert property (exec && ok && st.op == cag_pkg::OP_QUICK && !st.dst_mem // [RL6]
    |=> st.gpr[st.rd][7:0] == $past(chk_b[7:0]) && $stable(st.mem))
    else $error("quick register write wrong");
  a_quick_reject: assert property (exec && st.op == cag_pkg::OP_QUICK && !q_valid // [RL7]
    |=> st.bad && $stable(st.gpr) && $stable(st.mem) && $stable(st.flags))
    else $error("bad quick code not refused");
  a_quick_valid: assert property (exec && st.op == cag_pkg::OP_QUICK // [RL7]
    |-> q_valid == (st.qcode[7:4] == 4'h0 && st.qcode[3] && !st.qcode[1]))
    else $error("quick code acceptance wrong");
  a_quick_imm: assert property (exec && st.op == cag_pkg::OP_QUICK && q_valid // [RL8]
    |-> add_b == chk_qimm) else $error("quick immediate wrong");
  a_quick_code: assert property (exec && st.op == cag_pkg::OP_QUICK && st.qcode == cag_pkg::QC_MINUS2 // [RL8]
    && !st.dst_mem |=> st.gpr[st.rd] == $past(chk_w[15:0]) || !$past(st.word))
    else $error("minus two code wrong");
  a_sext_flags: assert property (exec && st.op == cag_pkg::OP_SEXT |=> $stable(st.flags)) // [RL9]
    else $error("sign-extending add touched flags");
  a_sext_word: assert property (exec && st.op == cag_pkg::OP_SEXT // [RL10]
    |=> st.gpr[st.rd] == $past(chk_sx)) else $error("sign-extending add result wrong");
  a_sext_full: assert property (exec && st.op == cag_pkg::OP_SEXT && !st.word && st.src[7] // [RL11]
    && dst_now[7:0] == 8'h00 |=> st.gpr[st.rd][15:8] == $past(dst_now[15:8]) - 8'h01)
    else $error("sign-extending add not word wide");
  a_byte_upper: assert property (exec && ok && !st.word && st.op != cag_pkg::OP_SEXT && !st.dst_mem // [RL12]
    |=> st.gpr[st.rd][15:8] == $past(dst_now[15:8])) else $error("byte add touched upper byte");

  // ----------------------------------------------------------------
  // Bus and fault flag checks
  // ----------------------------------------------------------------
  // A go landing in the execution cycle would be lost, so software must space them
  a_go_start: assert property (acc_wr && addr == cag_pkg::OFS_CTRL && pwdata[cag_pkg::CTRL_GO_BIT] |=> exec)
    else $error("go write did not start execution");
  a_exec_pulse: assert property (exec |=> !exec) else $error("execution longer than one cycle");
  a_bad_hold: assert property (bad_set || (st.bad && !bad_clr) |=> st.bad) // [RL7]
    else $error("fault flag lost");
  a_bad_clear: assert property (bad_clr && !bad_set |=> !st.bad) else $error("fault flag not cleared");
  a_err_unmapped: assert property (setup_done && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_apb_answer: assert property (setup_done |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_gen_word: cover property (exec && st.op == cag_pkg::OP_GEN && st.word);
  c_quick_mem: cover property (exec && st.op == cag_pkg::OP_QUICK && st.dst_mem && q_valid);
  c_quick_bad: cover property (exec && st.op == cag_pkg::OP_QUICK && !q_valid);
  c_sext_byte: cover property (exec && st.op == cag_pkg::OP_SEXT && !st.word);
  c_sext_neg: cover property (exec && st.op == cag_pkg::OP_SEXT && !st.word && st.src[7]);

endmodule // cag_exec

/* File: rtl/cag_qdec.sv */
// Purpose: Decode the quick-add operation byte into its immediate
// Assumes: Purely combinational, used inside the execution unit
// Notes: Any byte outside the four codes is flagged as not valid
`timescale 1ns/100ps
module cag_qdec (
  // Operation byte
  input wire logic [7:0] code,
  // Decoded immediate
  output logic [15:0] imm,
  output logic valid
);

  always_comb begin
    imm = cag_pkg::DATA_RST;
    valid = 1'b1;
    unique case (code)
      cag_pkg::QC_PLUS1: imm = cag_pkg::IMM_PLUS1;    // [RL8]
      cag_pkg::QC_PLUS2: imm = cag_pkg::IMM_PLUS2;    // [RL8]
      cag_pkg::QC_MINUS1: imm = cag_pkg::IMM_MINUS1;  // [RL8]
      cag_pkg::QC_MINUS2: imm = cag_pkg::IMM_MINUS2;  // [RL8]
      default: valid = 1'b0;                          // [RL7]
    endcase
  end

endmodule // cag_qdec

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the add-group execution unit
// Assumes: APB master driven on rising edges, one clock, async reset
// Notes: Table rows cover the general, quick and sign-extending adds; bad codes, errors and reset follow
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] op;
    logic word;
    logic [2:0] rd;
    logic mem;
    logic [7:0] qc;
    logic [15:0] src;
    logic [15:0] init;
    logic [15:0] res;
    logic [3:0] fl;
  } cag_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cag_pkg::cag_flags_t flags;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] rdat;
  logic err;
  cag_row_t rows [10] = '{
    '{2'h0, 1'b1, 3'h1, 1'b0, 8'h00, 16'h0001, 16'h7fff, 16'h8000, 4'ha},
    '{2'h0, 1'b0, 3'h2, 1'b0, 8'h00, 16'h0001, 16'h12ff, 16'h1200, 4'h5},
    '{2'h2, 1'b0, 3'h3, 1'b0, 8'h00, 16'h12ff, 16'h0010, 16'h000f, 4'h5},
    '{2'h2, 1'b1, 3'h4, 1'b0, 8'h00, 16'h0100, 16'h1234, 16'h1334, 4'h5},
    '{2'h1, 1'b1, 3'h5, 1'b0, 8'h09, 16'h1111, 16'h7ffe, 16'h8000, 4'ha},
    '{2'h1, 1'b0, 3'h6, 1'b0, 8'h0c, 16'h2222, 16'h0000, 16'h00ff, 4'h8},
    '{2'h1, 1'b1, 3'h7, 1'b0, 8'h08, 16'h3333, 16'h0001, 16'h0002, 4'h0},
    '{2'h1, 1'b1, 3'h1, 1'b0, 8'h0d, 16'h5555, 16'h0001, 16'hffff, 4'h8},
    '{2'h2, 1'b0, 3'h2, 1'b0, 8'h00, 16'h0080, 16'h0500, 16'h0480, 4'h8},
    '{2'h1, 1'b0, 3'h0, 1'b1, 8'h0d, 16'h4444, 16'h3480, 16'h347e, 4'h3}
  };

  cag_exec u_cag_exec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags(flags)
  );

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Counts: compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until pready is sampled high; bounded so a dead slave ends the run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      test_done();
    end else begin
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  function automatic logic [31:0] ctrl(input cag_row_t r);
    ctrl = (32'h1 << cag_pkg::CTRL_GO_BIT) | (32'(r.mem) << cag_pkg::CTRL_MEM_BIT)
      | (32'(r.rd) << cag_pkg::CTRL_RD_LSB) | (32'(r.word) << cag_pkg::CTRL_WORD_BIT) | 32'(r.op);
  endfunction

  function automatic logic [11:0] gpr_a(input logic [2:0] n);
    gpr_a = cag_pkg::OFS_GPR + {7'h00, n, 2'h0};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cag_pkg::OFS_STATUS, 32'h0);
    chk("status after reset", 32'h0, rdat);
    chk("status read error", 32'h0, 32'(err));
    chk("flags after reset", 32'h0, 32'(flags));
    apb(1'b0, gpr_a(3'h3), 32'h0);
    chk("gpr3 after reset", 32'h0, rdat);
    $display("TEST reset values done");

    foreach (rows[i]) begin
      apb(1'b1, cag_pkg::OFS_SRC, 32'(rows[i].src));
      apb(1'b1, cag_pkg::OFS_QCODE, 32'(rows[i].qc));
      apb(1'b1, rows[i].mem ? cag_pkg::OFS_MEM : gpr_a(rows[i].rd), 32'(rows[i].init));
      apb(1'b1, cag_pkg::OFS_CTRL, ctrl(rows[i]));
      apb(1'b0, rows[i].mem ? cag_pkg::OFS_MEM : gpr_a(rows[i].rd), 32'h0);
      chk("result", 32'(rows[i].res), rdat);
      apb(1'b0, cag_pkg::OFS_STATUS, 32'h0);
      chk("status flags", 32'(rows[i].fl), rdat);
      chk("flags port", 32'(rows[i].fl), 32'(flags));
      $display("TEST row %0d done", i);
    end

    // Code byte outside the four quick codes: no write, flags kept, bad latched
    apb(1'b1, gpr_a(3'h2), 32'h0050);
    apb(1'b1, cag_pkg::OFS_QCODE, 32'h0a);
    apb(1'b1, cag_pkg::OFS_CTRL, ctrl('{2'h1, 1'b1, 3'h2, 1'b0, 8'h0a, 16'h0, 16'h0, 16'h0, 4'h0}));
    apb(1'b0, gpr_a(3'h2), 32'h0);
    chk("gpr2 after bad quick", 32'h0050, rdat);
    apb(1'b0, cag_pkg::OFS_STATUS, 32'h0);
    chk("status after bad quick", 32'h13, rdat);
    apb(1'b1, cag_pkg::OFS_STATUS, 32'h10);
    apb(1'b1, cag_pkg::OFS_CTRL, ctrl('{2'h3, 1'b1, 3'h2, 1'b0, 8'h08, 16'h0, 16'h0, 16'h0, 4'h0}));
    apb(1'b0, cag_pkg::OFS_STATUS, 32'h0);
    chk("status after illegal op", 32'h13, rdat);
    apb(1'b1, cag_pkg::OFS_STATUS, 32'h10);
    apb(1'b0, cag_pkg::OFS_STATUS, 32'h0);
    chk("status after clear", 32'h03, rdat);
    $display("TEST refused operations done");

    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped read error", 32'h1, 32'(err));
    chk("unmapped read data", 32'h0, rdat);
    apb(1'b1, 12'h002, 32'hffff);
    chk("unaligned write error", 32'h1, 32'(err));
    $display("TEST bus errors done");

    // Reset in mid-run must wipe registers and flags
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("flags after second reset", 32'h0, 32'(flags));
    apb(1'b0, gpr_a(3'h1), 32'h0);
    chk("gpr1 after second reset", 32'h0, rdat);
    $display("TEST second reset done");
    test_done();
  end
endmodule // tb_top
